//--- sim/acs_host_model.sv
// Host model: drives setup register writes over the serial pins
`timescale 1ns/10ps
module acs_host_model
  import acs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic ser_sclk,
  output logic ser_din,
  output logic ser_cs_n,
  // Frame qualifiers
  output logic [2:0] wr_target,
  output logic wr_enable
);
  initial begin
    ser_sclk = 1'b1;
    ser_din = 1'b1;
    ser_cs_n = 1'b1;
    wr_target = 3'h0;
    wr_enable = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Fewer than 8 bits aborts the frame, as a broken transfer
  task automatic send(input logic [2:0] tgt, input logic en,
                      input logic [7:0] val, input int nbits);
    logic [7:0] v;
    v = val;
    if (tgt == SEL_SETUP_TWO) begin
      v[S2_RSVD] = 1'b0;
      if (v[S2_CAL_HI] & v[S2_CAL_LO]) v[S2_CAL_LO] = 1'b0;
    end
    tick(1);
    wr_target = tgt;
    wr_enable = en;
    ser_cs_n = 1'b0;
    tick(4);
    for (int i = 7; i > 7 - nbits; i--) begin
      ser_sclk = 1'b0;
      ser_din = v[i];
      tick(4);
      ser_sclk = 1'b1;
      tick(4);
    end
    // Long tail so the synchronised last edge lands inside the frame
    tick(8);
    ser_cs_n = 1'b1;
    ser_din = ~ser_din;
    tick(4);
    wr_enable = 1'b0;
    wr_target = 3'h0;
  endtask
endmodule

//--- sim/acs_sequencer_tb_top.sv
// Testbench of the channel sequencer and setup registers
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("MISMATCH t=%0t %s", $time, msg); \
  end \
end
module acs_sequencer_tb_top
  import acs_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n, ser_sclk, ser_din, ser_cs_n, wr_enable;
  logic tf_wr_strobe, conv_done, amp_enable, pair_mode, burnout_enable;
  logic clock_halve, mod_tick, single_stage, filt_reset, drdy_clear, t;
  logic [2:0] wr_target, scan_index;
  logic [1:0] tf_wr_index, active_tf;
  logic [7:0] setup_one_q, setup_two_q;
  logic [12:0] rate_sps;
  acs_chan_t active_chan, ch;
  int errors = 0, cmp_count = 0, fr_cnt = 0, dc_cnt = 0, f0, d0, n, k;
  logic [12:0] base [2][4] = '{'{RATE_LO_0, RATE_LO_1, RATE_LO_2, RATE_LO_3},
                              '{RATE_HI_0, RATE_HI_1, RATE_HI_2, RATE_HI_3}};

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (filt_reset === 1'b1) fr_cnt++;
    if (drdy_clear === 1'b1) dc_cnt++;
  end

  acs_host_model u_host (.mclk(mclk), .ser_sclk(ser_sclk),
    .ser_din(ser_din), .ser_cs_n(ser_cs_n), .wr_target(wr_target),
    .wr_enable(wr_enable));

  acs_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .ser_sclk(ser_sclk),
    .ser_din(ser_din), .ser_cs_n(ser_cs_n), .wr_target(wr_target),
    .wr_enable(wr_enable), .tf_wr_strobe(tf_wr_strobe),
    .tf_wr_index(tf_wr_index), .conv_done(conv_done),
    .setup_one_q(setup_one_q), .setup_two_q(setup_two_q),
    .active_chan(active_chan), .active_tf(active_tf),
    .scan_index(scan_index), .amp_enable(amp_enable),
    .pair_mode(pair_mode), .burnout_enable(burnout_enable),
    .clock_halve(clock_halve), .mod_tick(mod_tick),
    .single_stage(single_stage), .rate_sps(rate_sps),
    .filt_reset(filt_reset), .drdy_clear(drdy_clear));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wreg(input logic [2:0] sel, input logic [7:0] v);
    u_host.send(sel, 1'b1, v, 8);
    tick(3);
    if (sel == SEL_SETUP_ONE) `CHK(setup_one_q, v, "setup one")
    else `CHK(setup_two_q, v, "setup two")
  endtask

  task automatic pulse(input logic [1:0] idx, input logic cd);
    tf_wr_index = idx;
    tf_wr_strobe = ~cd;
    conv_done = cd;
    tick(1);
    tf_wr_strobe = 1'b0;
    conv_done = 1'b0;
    tick(3);
  endtask

  function automatic acs_chan_t pick(input int p, input int c, input int s);
    if (c == 1) return CH_OFFSET_CAL;
    if (c == 2) return CH_GAIN_CAL;
    if (p == 0) return acs_chan_t'(s);
    return (s == 0) ? CH_D12 : (s == 1) ? CH_D34 : CH_D56;
  endfunction

  function automatic logic [1:0] tf_of(input acs_chan_t c);
    case (c)
      CH_P1, CH_P2, CH_D12: return TF_ONE;
      CH_P3, CH_P4, CH_D34: return TF_TWO;
      default: return TF_THREE;
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    tf_wr_strobe = 1'b0;
    tf_wr_index = 2'h0;
    conv_done = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(3);
    `CHK(setup_one_q, SETUP_ONE_RST, "reset one")
    `CHK(setup_two_q, SETUP_TWO_RST, "reset two")
    `CHK(rate_sps, RATE_HI_1, "reset rate")
    `CHK(active_chan, CH_P1, "reset chan")
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 4; m++)
        for (int d = 0; d < 4; d++) begin
          wreg(SEL_SETUP_ONE, {2'b00, 2'(m), 1'(r), 2'(d), 1'(m == 3)});
          `CHK(rate_sps, 13'(base[r][d] << m), "rate")
          `CHK(single_stage, 1'(m == 3), "stage")
        end
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 3; c++)
        for (int s = 0; s < 4; s++) begin
          wreg(SEL_SETUP_TWO, {1'b0, 2'(c), 1'b0, 1'(p), 3'b000});
          wreg(SEL_SETUP_ONE, {2'(s), 6'b001010});
          `CHK(active_chan, pick(p, c, s), "chan")
          `CHK(active_tf, tf_of(pick(p, 0, s)), "tf")
          `CHK(pair_mode, 1'(p), "pair")
        end
    // Channel bits 11 must not disturb the scan
    wreg(SEL_SETUP_ONE, 8'hCA);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 3; c++) begin
        wreg(SEL_SETUP_TWO, {1'b1, 2'(c), 1'b0, 1'(p), 3'b000});
        n = (p ? 3 : 5) + (c ? 2 : 0);
        for (int i = 0; i <= n; i++) begin
          k = i % n;
          if (k >= (p ? 3 : 5))
            ch = (k == n - 2) ? CH_OFFSET_CAL : CH_GAIN_CAL;
          else ch = acs_chan_t'(p ? k + 5 : k);
          `CHK(scan_index, 3'(k), "scan index")
          `CHK(active_chan, ch, "scan chan")
          `CHK(active_tf, tf_of(ch), "scan tf")
          pulse(2'h0, 1'b1);
        end
      end
    // Select bits rewritten mid-scan: no restart, no filter reset
    f0 = fr_cnt;
    wreg(SEL_SETUP_ONE, 8'h0A);
    wreg(SEL_SETUP_ONE, 8'hCA);
    `CHK(fr_cnt - f0, 0, "select ignored")
    `CHK(scan_index, 3'h1, "scan kept index")
    `CHK(active_chan, CH_D34, "scan kept chan")
    f0 = fr_cnt;
    d0 = dc_cnt;
    wreg(SEL_SETUP_TWO, 8'h15);
    `CHK(amp_enable, 1'b1, "amp on")
    `CHK(burnout_enable, 1'b1, "burnout on")
    `CHK(clock_halve, 1'b1, "halve on")
    `CHK(fr_cnt - f0, 1, "filter reset")
    `CHK(dc_cnt - d0, 1, "ready clear")
    t = mod_tick;
    tick(1);
    `CHK(mod_tick, ~t, "tick toggles")
    wreg(SEL_SETUP_TWO, 8'h15);
    `CHK(fr_cnt - f0, 1, "no change no reset")
    wreg(SEL_SETUP_TWO, 8'h10);
    `CHK(burnout_enable, 1'b0, "burnout off")
    tick(1);
    `CHK(mod_tick, 1'b1, "tick steady")
    wreg(SEL_SETUP_TWO, 8'h00);
    `CHK(amp_enable, 1'b0, "amp off")
    `CHK(active_chan, CH_P4, "chan four")
    f0 = fr_cnt;
    pulse(TF_ONE, 1'b0);
    `CHK(fr_cnt - f0, 0, "inactive tf")
    pulse(TF_TWO, 1'b0);
    `CHK(fr_cnt - f0, 1, "active tf")
    u_host.send(SEL_SETUP_TWO, 1'b1, 8'h10, 4);
    tick(4);
    `CHK(setup_two_q, 8'h00, "partial byte")
    u_host.send(SEL_SETUP_TWO, 1'b0, 8'h10, 8);
    tick(4);
    `CHK(setup_two_q, 8'h00, "not a write")
    u_host.send(3'h3, 1'b1, 8'h10, 8);
    tick(4);
    `CHK(setup_two_q, 8'h00, "other target")
    wreg(SEL_SETUP_TWO, 8'h08);
    tally_and_finish();
  end
endmodule

//--- verilog/acs_byte_rx.sv
// Serial byte receiver: synchronises the pins, assembles whole bytes
`timescale 1ns/10ps
module acs_byte_rx
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial pins
  input wire logic ser_sclk,
  input wire logic ser_din,
  input wire logic ser_cs_n,
  // Assembled byte
  output logic [7:0] byte_r,
  output logic byte_vld_r
);

  logic [1:0] sclk_s_r;
  logic [1:0] din_s_r;
  logic [1:0] cs_s_r;
  logic sclk_d_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic rise;

  // Two-stage synchronisers, first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Idle-high level, so release never looks like a rising edge
      sclk_s_r <= 2'h3;
      din_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      sclk_d_r <= 1'b1;
    end else begin
      sclk_s_r <= {sclk_s_r[0], ser_sclk};
      din_s_r <= {din_s_r[0], ser_din};
      cs_s_r <= {cs_s_r[0], ser_cs_n};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  assign rise = sclk_s_r[1] & ~sclk_d_r & ~cs_s_r[1];

  // Nothing is released before the eighth bit has arrived
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_s_r[1]) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      byte_r <= 8'h00;
      byte_vld_r <= 1'b0;
    end else begin
      byte_vld_r <= 1'b0;
      if (rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r <= {shift_r[5:0], din_s_r[1]};
        if (bit_cnt_r == 3'h7) begin
          byte_r <= {shift_r, din_s_r[1]};
          byte_vld_r <= 1'b1;
        end
      end
    end
  end

endmodule

//--- verilog/acs_pkg.sv
// Shared constants and types of the channel sequencer and setup registers
package acs_pkg;

  // Register-select codes issued by the command logic
  localparam logic [2:0] SEL_SETUP_ONE = 3'h1;
  localparam logic [2:0] SEL_SETUP_TWO = 3'h2;

  // Reset values, first-sent bit is bit 7
  localparam logic [7:0] SETUP_ONE_RST = 8'h0A;
  localparam logic [7:0] SETUP_TWO_RST = 8'h00;

  // Setup one field positions
  localparam int S1_CHAN_HI = 7;
  localparam int S1_CHAN_LO = 6;
  localparam int S1_MOD_HI = 5;
  localparam int S1_MOD_LO = 4;
  localparam int S1_CLK_RANGE = 3;
  localparam int S1_DEC_HI = 2;
  localparam int S1_DEC_LO = 1;
  localparam int S1_SINGLE_STAGE = 0;

  // Setup two field positions
  localparam int S2_SCAN = 7;
  localparam int S2_CAL_HI = 6;
  localparam int S2_CAL_LO = 5;
  localparam int S2_AMP = 4;
  localparam int S2_PAIR = 3;
  localparam int S2_BURN = 2;
  localparam int S2_RSVD = 1;
  localparam int S2_HALVE = 0;

  // Scan lengths
  localparam logic [2:0] SIG_PSEUDO = 3'h5;
  localparam logic [2:0] SIG_PAIRED = 3'h3;
  localparam logic [2:0] CAL_EXTRA = 3'h2;

  // Base output rates in samples per second, modulator code 00
  localparam logic [12:0] RATE_LO_0 = 13'h0014;
  localparam logic [12:0] RATE_LO_1 = 13'h0019;
  localparam logic [12:0] RATE_LO_2 = 13'h0064;
  localparam logic [12:0] RATE_LO_3 = 13'h00C8;
  localparam logic [12:0] RATE_HI_0 = 13'h0032;
  localparam logic [12:0] RATE_HI_1 = 13'h003C;
  localparam logic [12:0] RATE_HI_2 = 13'h012C;
  localparam logic [12:0] RATE_HI_3 = 13'h0258;

  // Transfer-function register numbers
  localparam logic [1:0] TF_ONE = 2'h1;
  localparam logic [1:0] TF_TWO = 2'h2;
  localparam logic [1:0] TF_THREE = 2'h3;

  typedef enum logic [3:0] {
    CH_P1, CH_P2, CH_P3, CH_P4, CH_P5,
    CH_D12, CH_D34, CH_D56,
    CH_OFFSET_CAL, CH_GAIN_CAL
  } acs_chan_t;

endpackage

//--- verilog/acs_sequencer.sv
// Setup registers, channel selection, scan order and output rate
// What this block does
// - Scan bit set scans channels in order; clear repeats one selected channel.
// - Unscanned calibration code 00 normal, 01 offset pair, 10 gain pair.
// - Unscanned calibration uses transfer settings of channel picked by select.
// - Scanning with unequal calibration bits appends offset then gain conversion.
// - Scanned calibration conversions use transfer-function register three.
// - Scan order: five inputs vs common, or three pairs, then calibration.
// - Pairing bit 0 measures against common; 1 measures three pairs.
// - Unscanned normal offers four common-referenced inputs or three pairs.
// - Amplifier enable 0 bypasses and powers buffers down; 1 drives them.
// - Open-sensor bit connects test currents; host clears before measuring.
// - Halve bit divides master clock by two before internal use.
// - Low clock range gives 20/25/100/200 sps, doubling per modulator code.
// - High clock range gives 50/60/300/600 sps, doubling per modulator code.
// - Setup byte layouts and defaults as packed, first bit is bit 7.
// - Channel select bits are ignored while scanning.
// - Changing active channel settings drops data ready, resets filter.
`timescale 1ns/10ps
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial pins
  input wire logic ser_sclk,
  input wire logic ser_din,
  input wire logic ser_cs_n,
  // Command logic: target register and direction of the current frame
  input wire logic [2:0] wr_target,
  input wire logic wr_enable,
  // Transfer-function register write notice
  input wire logic tf_wr_strobe,
  input wire logic [1:0] tf_wr_index,
  // Conversion finished
  input wire logic conv_done,
  // Register readback
  output logic [7:0] setup_one_q,
  output logic [7:0] setup_two_q,
  // Channel selection
  output acs_chan_t active_chan,
  output logic [1:0] active_tf,
  output logic [2:0] scan_index,
  // Analog front-end controls
  output logic amp_enable,
  output logic pair_mode,
  output logic burnout_enable,
  output logic clock_halve,
  output logic mod_tick,
  output logic single_stage,
  output logic [12:0] rate_sps,
  // Filter control
  output logic filt_reset,
  output logic drdy_clear
);

  logic [7:0] rx_byte;
  logic rx_vld;
  logic [7:0] setup_one_r;
  logic [7:0] setup_two_r;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [2:0] seq_len;
  logic scan_on;
  logic pair_on;
  logic cal_scan;
  logic [1:0] cal_code;
  logic [1:0] chan_sel;
  acs_chan_t chan_nxt;
  logic [1:0] tf_nxt;
  logic wr_one;
  logic wr_two;
  logic [7:0] one_mask;
  logic setting_hit;
  logic restart;
  acs_chan_t chan_r;
  logic [1:0] tf_r;
  logic amp_r;
  logic pair_r;
  logic burn_r;
  logic halve_r;
  logic tick_r;
  logic stage_r;
  logic [12:0] rate_r;
  logic filt_r;
  logic drdy_clr_r;

  // Transfer-function register serving a channel
  function automatic logic [1:0] tf_of(input acs_chan_t ch);
    case (ch)
      CH_P1, CH_P2, CH_D12: tf_of = TF_ONE;
      CH_P3, CH_P4, CH_D34: tf_of = TF_TWO;
      default: tf_of = TF_THREE;
    endcase
  endfunction

  // Signal channel at a position within the signal part of a list
  function automatic acs_chan_t sig_chan(input logic pair,
                                         input logic [2:0] pos);
    case ({pair, pos})
      4'h0: sig_chan = CH_P1;
      4'h1: sig_chan = CH_P2;
      4'h2: sig_chan = CH_P3;
      4'h3: sig_chan = CH_P4;
      4'h4: sig_chan = CH_P5;
      4'h8: sig_chan = CH_D12;
      4'h9: sig_chan = CH_D34;
      default: sig_chan = CH_D56;
    endcase
  endfunction

  acs_byte_rx u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .ser_sclk(ser_sclk),
    .ser_din(ser_din),
    .ser_cs_n(ser_cs_n),
    .byte_r(rx_byte),
    .byte_vld_r(rx_vld)
  );

  assign wr_one = rx_vld & wr_enable & (wr_target == SEL_SETUP_ONE);
  assign wr_two = rx_vld & wr_enable & (wr_target == SEL_SETUP_TWO);

  // Whole bytes only; reserved bit stored as written
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setup_one_r <= SETUP_ONE_RST;
      setup_two_r <= SETUP_TWO_RST;
    end else begin
      if (wr_one)
        setup_one_r <= rx_byte;
      if (wr_two)
        setup_two_r <= rx_byte;
    end
  end

  assign scan_on = setup_two_r[S2_SCAN];
  assign pair_on = setup_two_r[S2_PAIR];
  assign cal_code = {setup_two_r[S2_CAL_HI], setup_two_r[S2_CAL_LO]};
  assign chan_sel = {setup_one_r[S1_CHAN_HI], setup_one_r[S1_CHAN_LO]};
  assign cal_scan = cal_code[1] ^ cal_code[0];

  // Signal inputs first, then offset and gain calibration
  always_comb begin
    seq_len = pair_on ? SIG_PAIRED : SIG_PSEUDO;
    if (cal_scan)
      seq_len = seq_len + CAL_EXTRA;
  end

  // Channel and transfer register for the present position
  always_comb begin
    chan_nxt = CH_P1;
    tf_nxt = TF_ONE;
    if (scan_on) begin
      if (idx_r < (pair_on ? SIG_PAIRED : SIG_PSEUDO)) begin
        chan_nxt = sig_chan(pair_on, idx_r);
        tf_nxt = tf_of(chan_nxt);
      end else begin
        chan_nxt = (idx_r == (pair_on ? SIG_PAIRED : SIG_PSEUDO)) ?
                   CH_OFFSET_CAL : CH_GAIN_CAL;
        tf_nxt = TF_THREE;
      end
    end else begin
      // Select 3 in pair mode has no fourth pair; it lands on the last
      chan_nxt = sig_chan(pair_on, {1'b0, chan_sel});
      tf_nxt = tf_of(chan_nxt);
      case (cal_code)
        2'h1: chan_nxt = CH_OFFSET_CAL;
        2'h2: chan_nxt = CH_GAIN_CAL;
        default: ;
      endcase
    end
  end

  // Select bits do not count as an active setting while scanning
  assign one_mask = scan_on ? 8'h3F : 8'hFF;

  always_comb begin
    setting_hit = 1'b0;
    if (wr_one && |((rx_byte ^ setup_one_r) & one_mask))
      setting_hit = 1'b1;
    if (wr_two && |(rx_byte ^ setup_two_r))
      setting_hit = 1'b1;
    if (tf_wr_strobe && (tf_wr_index == tf_r))
      setting_hit = 1'b1;
  end

  // Restarting the scan avoids running past a list that got shorter
  assign restart = setting_hit & (wr_one | wr_two);

  always_comb begin
    idx_nxt = idx_r;
    if (!scan_on || restart)
      idx_nxt = 3'h0;
    else if (conv_done)
      idx_nxt = (idx_r == seq_len - 3'h1) ? 3'h0 : idx_r + 3'h1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      idx_r <= 3'h0;
    else
      idx_r <= idx_nxt;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chan_r <= CH_P1;
      tf_r <= TF_ONE;
    end else begin
      chan_r <= chan_nxt;
      tf_r <= tf_nxt;
    end
  end

  // Front-end controls follow the stored fields
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      amp_r <= 1'b0;
      pair_r <= 1'b0;
      burn_r <= 1'b0;
      halve_r <= 1'b0;
      stage_r <= 1'b0;
    end else begin
      amp_r <= setup_two_r[S2_AMP];
      pair_r <= pair_on;
      burn_r <= setup_two_r[S2_BURN];
      halve_r <= setup_two_r[S2_HALVE];
      stage_r <= setup_one_r[S1_SINGLE_STAGE];
    end
  end

  // Internal clock tick: every edge, or every other edge when halved
  always_ff @(posedge mclk) begin
    if (!rst_n)
      tick_r <= 1'b1;
    else if (setup_two_r[S2_HALVE])
      tick_r <= ~tick_r;
    else
      tick_r <= 1'b1;
  end

  // Output rate: base by range and decimation, doubled per modulator step
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rate_r <= RATE_HI_1;
    end else begin
      case ({setup_one_r[S1_CLK_RANGE], setup_one_r[S1_DEC_HI],
             setup_one_r[S1_DEC_LO]})
        3'h0: rate_r <= RATE_LO_0 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h1: rate_r <= RATE_LO_1 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h2: rate_r <= RATE_LO_2 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h3: rate_r <= RATE_LO_3 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h4: rate_r <= RATE_HI_0 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h5: rate_r <= RATE_HI_1 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        3'h6: rate_r <= RATE_HI_2 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
        default: rate_r <= RATE_HI_3 << setup_one_r[S1_MOD_HI:S1_MOD_LO];
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      filt_r <= 1'b0;
      drdy_clr_r <= 1'b0;
    end else begin
      filt_r <= setting_hit;
      drdy_clr_r <= setting_hit;
    end
  end

  assign setup_one_q = setup_one_r;
  assign setup_two_q = setup_two_r;
  assign active_chan = chan_r;
  assign active_tf = tf_r;
  assign scan_index = idx_r;
  assign amp_enable = amp_r;
  assign pair_mode = pair_r;
  assign burnout_enable = burn_r;
  assign clock_halve = halve_r;
  assign mod_tick = tick_r;
  assign single_stage = stage_r;
  assign rate_sps = rate_r;
  assign filt_reset = filt_r;
  assign drdy_clear = drdy_clr_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  scan_wrap_a: assert property (
    scan_on && !restart && conv_done && idx_r == seq_len - 3'h1
    |=> idx_r == 3'h0) else $error("scan did not wrap");
  single_hold_a: assert property (
    !scan_on ##1 !scan_on |-> idx_r == 3'h0)
    else $error("index moved with scan off");
  cal_offset_a: assert property (
    !scan_on && cal_code == 2'h1 && $stable(setup_two_r)
    |=> active_chan == CH_OFFSET_CAL) else $error("offset pair not chosen");
  cal_tf_scan_a: assert property (
    scan_on && $past(scan_on)
    && (chan_r == CH_OFFSET_CAL || chan_r == CH_GAIN_CAL)
    |-> tf_r == TF_THREE) else $error("scan calibration tf wrong");
  cal_order_a: assert property (
    scan_on && chan_r == CH_OFFSET_CAL && conv_done && !setting_hit
    && $stable(setup_two_r) |=> ##1 chan_r == CH_GAIN_CAL)
    else $error("gain did not follow offset");
  halve_tick_a: assert property (
    setup_two_r[S2_HALVE] && $past(setup_two_r[S2_HALVE])
    |=> tick_r != $past(tick_r)) else $error("tick not halved");
  whole_byte_a: assert property (
    !$stable(setup_one_r) |-> $past(wr_one))
    else $error("setup one changed without byte");
  change_reset_a: assert property (
    wr_two && rx_byte != setup_two_r |=> filt_reset && drdy_clear)
    else $error("filter not reset on change");
  sel_ignored_a: assert property (
    scan_on && wr_one && (rx_byte[5:0] == setup_one_r[5:0])
    && !tf_wr_strobe |=> !filt_reset)
    else $error("select change reset filter while scanning");
  rate_max_a: assert property (
    setup_one_r[S1_CLK_RANGE:S1_DEC_LO] == 3'h7
    && setup_one_r[S1_MOD_HI:S1_MOD_LO] == 2'h3
    && $stable(setup_one_r) |=> rate_sps == 13'h12C0)
    else $error("top rate wrong");

  scan_cal_c: cover property (scan_on && chan_r == CH_GAIN_CAL);
  input_pairing_select_scan_c: cover property (scan_on && pair_on && chan_r == CH_D56);
  tf_reset_c: cover property (tf_wr_strobe && tf_wr_index == tf_r);

endmodule
